// *** hw/trim_pkg.sv ***
/*
 * Constants for the phase and offset trim block: register indices, field widths,
 * reset values and timing counts.
 * Assumes a single 125 MHz master clock and a plain word-wide register port.
 */
package trim_pkg;
    // Register indices on the plain register port.
    localparam logic [3:0] ADDR_PHASE_TRIM  = 4'h0;
    localparam logic [3:0] ADDR_OFFSET      = 4'h1;
    localparam logic [3:0] ADDR_HALF_CYCLES = 4'h2;
    localparam logic [3:0] ADDR_CONTROL     = 4'h3;
    localparam logic [3:0] ADDR_STATUS      = 4'h4;
    localparam logic [3:0] ADDR_ENERGY      = 4'h5;
    localparam logic [3:0] ADDR_LINE_ENERGY = 4'h6;
    localparam logic [3:0] ADDR_PERIOD      = 4'h7;

    // Field layout.
    localparam int TRIM_W       = 6;
    localparam int SAMPLE_W     = 16;
    localparam int OFFSET_W     = 16;
    localparam int HALF_W       = 16;
    localparam int ENERGY_W     = 24;
    localparam int PERIOD_W     = 16;
    localparam int ACC_W        = 40;
    localparam int FRAC_BITS    = 8;
    localparam int CTRL_LINE_EN = 0;
    localparam int STAT_DONE    = 0;

    // Reset values.
    localparam logic [TRIM_W-1:0]   PHASE_TRIM_RST = 6'h0D;
    localparam logic [TRIM_W-1:0]   PHASE_CENTRE   = 6'h0D;
    localparam logic [OFFSET_W-1:0] OFFSET_RST     = 16'h0000;
    localparam logic [HALF_W-1:0]   HALF_RST       = 16'h0000;

    // Timing: trim step and period tick every 8 clocks, energy update every 4.
    localparam int CLK_MHZ        = 125;
    localparam int STEP_CLKS      = 8;
    localparam int ENERGY_CLKS    = 4;
    localparam int DELAY_TAPS     = 64;
    localparam logic [5:0] CENTRE_TAP = 6'h2D;
endpackage : trim_pkg

// *** hw/trim_if.sv ***
/*
 * Bundle between the trim core and its sample delay line.
 * Assumes both ends run on the same master clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface trim_if;
    import trim_pkg::*;
    logic                       step;
    logic [TRIM_W-1:0]          trim;
    logic signed [SAMPLE_W-1:0] v_raw;
    logic signed [SAMPLE_W-1:0] i_raw;
    logic signed [SAMPLE_W-1:0] v_shift;
    logic signed [SAMPLE_W-1:0] i_shift;
    modport core (output step, trim, v_raw, i_raw, input v_shift, i_shift);
    modport line (input step, trim, v_raw, i_raw, output v_shift, i_shift);
endinterface : trim_if
`default_nettype wire

// *** hw/sample_delay.sv ***
/*
 * Delay lines for the voltage and current sample streams.
 * Assumes one step strobe every eight clocks from the core.
 */
`timescale 1ns/1ps
`default_nettype none
module sample_delay
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    trim_if.line      bus
);
    import trim_pkg::*;

    logic signed [SAMPLE_W-1:0] v_line_q [DELAY_TAPS];
    logic signed [SAMPLE_W-1:0] i_line_q [DELAY_TAPS];
    logic [5:0]                 tap;

    // Signed trim plus 32 picks the tap; the centre code lands on the fixed current tap.
    assign tap = {~bus.trim[TRIM_W-1], bus.trim[TRIM_W-2:0]};

    genvar g;
    generate
        for (g = 1; g < DELAY_TAPS; g++)
        begin : g_line
            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                begin
                    v_line_q[g] <= '0;
                    i_line_q[g] <= '0;
                end
                else if (bus.step)
                begin
                    v_line_q[g] <= v_line_q[g-1];
                    i_line_q[g] <= i_line_q[g-1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            v_line_q[0] <= '0;
            i_line_q[0] <= '0;
        end
        else if (bus.step)
        begin
            v_line_q[0] <= bus.v_raw;
            i_line_q[0] <= bus.i_raw;
        end
    end

    // Voltage tap moves with the trim, current stays at the centre tap.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            bus.v_shift <= '0;
            bus.i_shift <= '0;
        end
        else
        begin
            bus.v_shift <= v_line_q[tap];
            bus.i_shift <= i_line_q[CENTRE_TAP];
        end
    end
endmodule : sample_delay
`default_nettype wire

// *** hw/phase_offset_trim.sv ***
/*
 * Phase trim of the voltage sample path, offset-corrected active energy
 * accumulation and line-cycle energy accumulation, with a plain register port.
 * Assumes voltage and current samples come from logic on the same clock.
 */
// The plain strobed port and the register addresses are this design's own decisions.
// Functional notes
// - Shift voltage samples earlier or later by trim.
// - Shift equals (trim minus 13) times eight clocks.
// - Above 13 delays, below advances, equal none.
// - Range covers 2.88 us lead, 1.152 us lag.
// - Phase trim read as signed two's complement.
// - Correction opposes error, scaled by line period; the code shifts a fixed eight clocks per trim code and does not use the period.
// - Line energy latched after programmed half cycles.
// - Energy updated every four clocks with offset.
// - Offset low eight bits are fractional.
`timescale 1ns/1ps
`default_nettype none
module phase_offset_trim
(
    input  wire logic                                     clk_in,
    input  wire logic                                     rst_in,
    input  wire logic [3:0]                               addr_in,
    input  wire logic [31:0]                              wdata_in,
    input  wire logic                                     wr_in,
    input  wire logic                                     rd_in,
    output var  logic [31:0]                              rdata_out,
    input  wire logic signed [trim_pkg::SAMPLE_W-1:0]     voltage_in,
    input  wire logic signed [trim_pkg::SAMPLE_W-1:0]     current_in,
    output var  logic signed [trim_pkg::SAMPLE_W-1:0]     voltage_trim_out,
    output var  logic signed [trim_pkg::SAMPLE_W-1:0]     current_trim_out,
    output var  logic                                     line_done_out
);
    import trim_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    typedef enum logic [1:0] {
        LINE_IDLE = 2'b00,
        LINE_SYNC = 2'b01,
        LINE_RUN  = 2'b11
    } line_state_t;

    logic [2:0]                 step_cnt_q;
    logic [1:0]                 energy_cnt_q;
    logic                       step_q;
    logic [TRIM_W-1:0]          phase_trim_q;
    logic [OFFSET_W-1:0]        active_power_offset_q;
    logic [HALF_W-1:0]          half_cycle_count_q;
    logic                       line_en_q;
    logic                       done_q;
    logic signed [ACC_W-1:0]    acc_q;
    logic signed [ACC_W-1:0]    line_acc_q;
    logic signed [ACC_W-1:0]    inc_d;
    logic [ENERGY_W-1:0]        line_active_energy_q;
    logic [PERIOD_W-1:0]        period_cnt_q;
    logic [PERIOD_W-1:0]        period_q;
    logic [HALF_W-1:0]          half_seen_q;
    logic                       sign_q;
    logic                       half_evt;
    logic                       rise_evt;
    logic                       line_latch;
    line_state_t                line_state_q;
    logic signed [2*SAMPLE_W-1:0] product;

    trim_if link ();

    function automatic logic hit(input logic [3:0] a, input logic [3:0] reg_addr);
        hit = (a == reg_addr);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////////
    // Time base: trim steps and period ticks every 8 clocks, energy every 4.

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            step_cnt_q <= 3'h0;
            step_q     <= 1'b0;
        end
        else
        begin
            step_cnt_q <= step_cnt_q + 3'h1;
            step_q     <= (step_cnt_q == 3'(STEP_CLKS - 1));
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            energy_cnt_q <= 2'h0;
        end
        else
        begin
            energy_cnt_q <= energy_cnt_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Delay lines.

    assign link.step  = step_q;
    assign link.trim  = phase_trim_q;
    assign link.v_raw = voltage_in;
    assign link.i_raw = current_in;

    sample_delay u_delay
    (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .bus    (link)
    );

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            voltage_trim_out <= '0;
            current_trim_out <= '0;
        end
        else
        begin
            voltage_trim_out <= link.v_shift;
            current_trim_out <= link.i_shift;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Active energy: product of aligned samples plus fractional offset.

    assign product = link.v_shift * link.i_shift;

    always_comb
    begin
        inc_d = ACC_W'(signed'(product[2*SAMPLE_W-1:SAMPLE_W-FRAC_BITS]))
              + ACC_W'(signed'(active_power_offset_q));
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            acc_q <= '0;
        end
        else if (energy_cnt_q == 2'(ENERGY_CLKS - 1))
        begin
            acc_q <= acc_q + inc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Zero crossings and line period.

    assign half_evt = step_q && (sign_q != link.v_shift[SAMPLE_W-1]);
    assign rise_evt = half_evt && sign_q;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sign_q <= 1'b0;
        end
        else if (step_q)
        begin
            sign_q <= link.v_shift[SAMPLE_W-1];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            period_cnt_q <= '0;
            period_q     <= '0;
        end
        else if (rise_evt)
        begin
            period_q     <= period_cnt_q + PERIOD_W'(1);
            period_cnt_q <= '0;
        end
        else if (step_q && period_cnt_q != {PERIOD_W{1'b1}})
        begin
            period_cnt_q <= period_cnt_q + PERIOD_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Line-cycle accumulation.

    assign line_latch = (line_state_q == LINE_RUN) && half_evt
                     && (half_seen_q + HALF_W'(1) >= half_cycle_count_q);

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            line_state_q <= LINE_IDLE;
            half_seen_q  <= '0;
        end
        else if (!line_en_q)
        begin
            line_state_q <= LINE_IDLE;
            half_seen_q  <= '0;
        end
        else
        begin
            case (line_state_q)
                LINE_IDLE: line_state_q <= LINE_SYNC;
                LINE_SYNC:
                begin
                    if (half_evt)
                    begin
                        line_state_q <= LINE_RUN;
                        half_seen_q  <= '0;
                    end
                end
                LINE_RUN:
                begin
                    if (line_latch)
                    begin
                        half_seen_q <= '0;
                    end
                    else if (half_evt)
                    begin
                        half_seen_q <= half_seen_q + HALF_W'(1);
                    end
                end
                default: line_state_q <= LINE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            line_acc_q           <= '0;
            line_active_energy_q <= '0;
        end
        else if (line_state_q != LINE_RUN || line_latch)
        begin
            if (line_latch)
            begin
                line_active_energy_q <= line_acc_q[FRAC_BITS +: ENERGY_W];
            end
            line_acc_q <= '0;
        end
        else if (energy_cnt_q == 2'(ENERGY_CLKS - 1))
        begin
            line_acc_q <= line_acc_q + inc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port.

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            phase_trim_q          <= PHASE_TRIM_RST;
            active_power_offset_q <= OFFSET_RST;
            half_cycle_count_q    <= HALF_RST;
            line_en_q             <= 1'b0;
        end
        else if (wr_in)
        begin
            if (hit(addr_in, ADDR_PHASE_TRIM))
            begin
                phase_trim_q <= wdata_in[TRIM_W-1:0];
            end
            else if (hit(addr_in, ADDR_OFFSET))
            begin
                active_power_offset_q <= wdata_in[OFFSET_W-1:0];
            end
            else if (hit(addr_in, ADDR_HALF_CYCLES))
            begin
                half_cycle_count_q <= wdata_in[HALF_W-1:0];
            end
            else if (hit(addr_in, ADDR_CONTROL))
            begin
                line_en_q <= wdata_in[CTRL_LINE_EN];
            end
        end
    end

    // Done flag: set wins over a write-one clear in the same cycle.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            done_q <= 1'b0;
        end
        else if (line_latch)
        begin
            done_q <= 1'b1;
        end
        else if (wr_in && hit(addr_in, ADDR_STATUS) && wdata_in[STAT_DONE])
        begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            line_done_out <= 1'b0;
        end
        else
        begin
            line_done_out <= done_q;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rdata_out <= 32'h0000_0000;
        end
        else if (!rd_in)
        begin
            rdata_out <= 32'h0000_0000;
        end
        else if (hit(addr_in, ADDR_PHASE_TRIM))
        begin
            rdata_out <= 32'(phase_trim_q);
        end
        else if (hit(addr_in, ADDR_OFFSET))
        begin
            rdata_out <= 32'(active_power_offset_q);
        end
        else if (hit(addr_in, ADDR_HALF_CYCLES))
        begin
            rdata_out <= 32'(half_cycle_count_q);
        end
        else if (hit(addr_in, ADDR_CONTROL))
        begin
            rdata_out <= 32'(line_en_q);
        end
        else if (hit(addr_in, ADDR_STATUS))
        begin
            rdata_out <= 32'(done_q);
        end
        else if (hit(addr_in, ADDR_ENERGY))
        begin
            rdata_out <= 32'(acc_q[FRAC_BITS +: ENERGY_W]);
        end
        else if (hit(addr_in, ADDR_LINE_ENERGY))
        begin
            rdata_out <= 32'(line_active_energy_q);
        end
        else if (hit(addr_in, ADDR_PERIOD))
        begin
            rdata_out <= 32'(period_q);
        end
        else
        begin
            rdata_out <= 32'h0000_0000;
        end
    end
endmodule : phase_offset_trim
`default_nettype wire

// *** verification/phase_offset_trim_chk.sv ***
/*
 * Port checker for the phase and offset trim block.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module phase_offset_trim_chk
    import trim_pkg::*;
(
    input wire logic                       clk_in,
    input wire logic                       rst_in,
    input wire logic [3:0]                 addr_in,
    input wire logic [31:0]                wdata_in,
    input wire logic                       wr_in,
    input wire logic                       rd_in,
    input wire logic [31:0]                rdata_out,
    input wire logic signed [SAMPLE_W-1:0] voltage_in,
    input wire logic signed [SAMPLE_W-1:0] current_in,
    input wire logic signed [SAMPLE_W-1:0] voltage_trim_out,
    input wire logic signed [SAMPLE_W-1:0] current_trim_out,
    input wire logic                       line_done_out
);
    logic clr_q;
    always_ff @(posedge clk_in)
    begin
        clr_q <= wr_in && addr_in == ADDR_STATUS && wdata_in[0];
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    sequence trim_wr_s;
        wr_in && addr_in == ADDR_PHASE_TRIM;
    endsequence
    sequence trim_rd_s;
        rd_in && addr_in == ADDR_PHASE_TRIM;
    endsequence
    sequence ofs_wr_s;
        wr_in && addr_in == ADDR_OFFSET;
    endsequence
    sequence ofs_rd_s;
        rd_in && addr_in == ADDR_OFFSET;
    endsequence
    read_idle_a: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (rd_in && addr_in[3] |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    trim_width_a: assert property (trim_rd_s |=> rdata_out[31:TRIM_W] == '0)
        else $error("phase trim upper bits set");
    trim_echo_a: assert property (trim_wr_s ##1 trim_rd_s |=>
        rdata_out == ($past(wdata_in, 2) & 32'h0000_003F))
        else $error("phase trim read back wrong");
    offset_echo_a: assert property (ofs_wr_s ##1 ofs_rd_s |=>
        rdata_out == ($past(wdata_in, 2) & 32'h0000_FFFF))
        else $error("offset read back wrong");
    status_mirror_a: assert property (rd_in && addr_in == ADDR_STATUS |=>
        rdata_out == {31'h0, line_done_out})
        else $error("status read disagrees with done output");
    done_clear_a: assert property ($fell(line_done_out) |-> $past(clr_q))
        else $error("done dropped without a clear");
    vstep_a: assert property ($changed(voltage_trim_out) |=> (!$changed(voltage_trim_out))[*7])
        else $error("voltage output changed within a step");
    istep_a: assert property ($changed(current_trim_out) |=> (!$changed(current_trim_out))[*7])
        else $error("current output changed within a step");
endmodule : phase_offset_trim_chk
bind phase_offset_trim phase_offset_trim_chk chk (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .voltage_in(voltage_in), .current_in(current_in),
    .voltage_trim_out(voltage_trim_out), .current_trim_out(current_trim_out),
    .line_done_out(line_done_out));
`default_nettype wire

// *** verification/test_phase_offset_trim.sv ***
/*
 * Self-checking bench for the phase and offset trim block.
 * Assumes the checker is bound to the design and a 125 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module test_phase_offset_trim;
    import trim_pkg::*;
    logic               clk_in;
    logic               rst_in;
    logic [3:0]         addr_in;
    logic [31:0]        wdata_in;
    logic               wr_in;
    logic               rd_in;
    logic [31:0]        rdata_out;
    logic signed [15:0] voltage_in;
    logic signed [15:0] current_in;
    logic signed [15:0] voltage_trim_out;
    logic signed [15:0] current_trim_out;
    logic               line_done_out;
    int                 num_errors = 0;
    int                 n_tests = 0;
    int                 ph = 0;
    bit                 sq_on = 0;
    int                 tv;
    int                 ti;
    logic [31:0]        rv;
    logic [31:0]        e0;
    logic [5:0]         trims [7] = '{6'h0D, 6'h0E, 6'h0C, 6'h00, 6'h1F, 6'h20, 6'h11};
    logic [15:0]        offs [5] = '{16'h0100, 16'h0040, 16'hFF00, 16'h8000, 16'h0};
    int                 halves [3] = '{0, 1, 3};

    phase_offset_trim dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .voltage_in(voltage_in), .current_in(current_in),
        .voltage_trim_out(voltage_trim_out), .current_trim_out(current_trim_out),
        .line_done_out(line_done_out));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One bus cycle; also flips the square-wave voltage every 160 clocks.
    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= d;
        if (sq_on)
        begin
            ph = ph + 1;
            if (ph == 160)
            begin
                ph = 0;
                voltage_in <= -voltage_in;
            end
        end
    endtask : bus

    task automatic ticks(input int n);
        repeat (n) bus(1'b0, 1'b0, addr_in, wdata_in);
    endtask : ticks

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        bus(1'b0, 1'b1, a, 32'h0);
        ticks(1);
        #1;
        v = rdata_out;
    endtask : rd

    task automatic wait_done();
        ticks(2);
        for (int k = 0; k < 2000; k++)
        begin
            #1;
            if (line_done_out === 1'b1)
            begin
                return;
            end
            ticks(1);
        end
        num_errors++;
        final_report();
    endtask : wait_done

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    initial
    begin
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 32'h0;
        voltage_in = 16'sh0;
        current_in = 16'sh0;
        void'($urandom(11));
        trims[6] = 6'($urandom);
        offs[4] = 16'($urandom);
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            rd(4'(k), rv);
            check("reset value", rv, (k == 0) ? 32'h0000_000D : 32'h0);
        end
        wr(4'h9, $urandom);
        rd(4'h9, rv);
        check("unmapped", rv, 32'h0);
        wr(ADDR_ENERGY, 32'hFFFF_FFFF);
        rd(ADDR_ENERGY, rv);
        check("energy read only", rv, 32'h0);
        foreach (trims[k])
        begin
            voltage_in <= 16'sh0;
            current_in <= 16'sh0;
            ticks(600);
            wr(ADDR_PHASE_TRIM, {26'h0, trims[k]});
            rd(ADDR_PHASE_TRIM, rv);
            check("phase trim", rv, {26'h0, trims[k]});
            ticks(16);
            rv = 32'($urandom_range(32767, 1));
            voltage_in <= rv[15:0];
            current_in <= rv[15:0];
            tv = -1;
            ti = -1;
            for (int n = 0; n < 1000 && (tv < 0 || ti < 0); n++)
            begin
                ticks(1);
                #1;
                if (tv < 0 && voltage_trim_out !== 16'sh0) tv = n;
                if (ti < 0 && current_trim_out !== 16'sh0) ti = n;
            end
            if (tv < 0 || ti < 0)
            begin
                num_errors++;
                final_report();
            end
            check("voltage value", 32'(voltage_trim_out), rv);
            check("shift", 32'(tv - ti), 32'(($signed(trims[k]) - 13) * 8));
        end
        voltage_in <= 16'sh0;
        current_in <= 16'sh0;
        ticks(600);
        foreach (offs[k])
        begin
            wr(ADDR_OFFSET, {16'h0, offs[k]});
            rd(ADDR_OFFSET, rv);
            check("offset", rv, {16'h0, offs[k]});
            ticks(8);
            rd(ADDR_ENERGY, e0);
            ticks(1022);
            rd(ADDR_ENERGY, rv);
            check("energy", rv, (e0 + {{16{offs[k][15]}}, offs[k]}) & 32'h00FF_FFFF);
        end
        wr(ADDR_OFFSET, 32'h0000_0100);
        voltage_in <= 16'sd1000;
        sq_on = 1'b1;
        ticks(1200);
        foreach (halves[k])
        begin
            wr(ADDR_HALF_CYCLES, 32'(halves[k]));
            wr(ADDR_CONTROL, 32'h1);
            wr(ADDR_STATUS, 32'h1);
            wait_done();
            rd(ADDR_STATUS, rv);
            check("done", rv, 32'h1);
            wr(ADDR_STATUS, 32'h1);
            ticks(3);
            #1;
            check("done cleared", {31'h0, line_done_out}, 32'h0);
            wait_done();
            rd(ADDR_LINE_ENERGY, rv);
            check("line energy", rv, 32'((halves[k] == 0 ? 1 : halves[k]) * 40));
            rd(ADDR_PERIOD, rv);
            check("period", rv, 32'd40);
        end
        final_report();
    end
endmodule : test_phase_offset_trim
`default_nettype wire
